// File: core_irq_flow.sv
// Purpose: Interrupt gating, reset cause, trim and program-flow control.
// Assumes: One 25 MHz clock, Wishbone classic slave, 8-bit registers.
// Notes: Event inputs come from logic on the same clock.
// Overview of operation
// - Flags set regardless of any enable
// - Control bit 7 gates all interrupts
// - Peripheral sources also need control bit 6
// - Control holds three enables and sticky flags
// - Peripheral enables at bits 7,6,3,0
// - Peripheral flags at bits 7,6,3,0, sticky
// - Power-on bit reads 0 after power-on
// - Brown-out bit cleared by event, software sets
// - Six-bit trim in bits 7 to 2
// - Thirteen-bit counter, low byte register
// - Every reset clears the program counter
// - Low byte write loads latch bits 4:0
// - Call and jump take latch bits 4:3
// - Eight hidden stack entries of 13 bits
// - Push on call or interrupt, pop on returns
// - Stack wraps as circular buffer
// - No overflow or underflow indication
// - Indirect port redirects; self access does nothing
// - Indirect address is bank bit plus pointer
// - Pin change compares against last port read or write
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module core_irq_flow
	import core_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Wishbone register bus.
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [ADR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdat,
	output logic [31:0] wb_rdat,
	output logic wb_ack,
	// Instruction sequencer.
	input wire logic seq_step,
	input wire logic seq_call,
	input wire logic seq_goto,
	input wire logic seq_ret,
	input wire logic seq_return_from_irq,
	input wire logic seq_irq_branch,
	input wire logic [JMP_W-1:0] seq_addr,
	output logic [PC_W-1:0] pc,
	output logic irq_req,
	// Peripheral events.
	input wire logic ev_timer_zero_ovf,
	input wire logic ev_ext_pin,
	input wire logic ev_mem_write_done,
	input wire logic ev_conversion_done,
	input wire logic ev_comparator_change,
	input wire logic ev_timer_one_ovf,
	input wire logic ev_brownout,
	// Pins and oscillator.
	input wire logic [PORT_W-1:0] port_a_pins,
	output logic [5:0] osc_trim_code
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	generate
		if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
			$error("Stack depth must be a power of two.");
		end
	endgenerate

	typedef struct packed {
		logic ack;
		logic [7:0] rdat;
		logic [7:0] irq_ctl;
		logic [7:0] pir;
		logic [7:0] pie;
		logic [7:0] rst_cause;
		logic [7:0] osc;
		logic [7:0] latch;
		logic [7:0] ptr;
		logic bank;
		logic [PORT_W-1:0] chg_mask;
		logic [PORT_W-1:0] last;
		logic [PORT_W-1:0] s1;
		logic [PORT_W-1:0] s2;
		logic [PORT_W-1:0] s3;
		logic [PORT_W-1:0] pins;
		logic [PC_W-1:0] pc;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
		logic [SP_W-1:0] sp;
		logic irq;
	} state_t;

	state_t r;
	state_t n;

	function automatic logic is_self(input logic [7:0] a);
		is_self = (a == IDX_IND_PORT) || (a == IDX_IND_PORT_B1);
	endfunction

	function automatic logic [7:0] rd_reg(input state_t s,
		input logic [7:0] a);
		case (a)
			IDX_PC_LOW: rd_reg = s.pc[7:0];
			IDX_BANK: rd_reg = {s.bank, 7'h00};
			IDX_IND_PTR: rd_reg = s.ptr;
			IDX_PORT_A: rd_reg = {2'h0, s.pins};
			IDX_PC_LATCH: rd_reg = s.latch;
			IDX_IRQ_CTL: rd_reg = s.irq_ctl;
			IDX_PER_FLAG: rd_reg = s.pir;
			IDX_PER_EN: rd_reg = s.pie;
			IDX_RST_CAUSE: rd_reg = s.rst_cause;
			IDX_OSC_TRIM: rd_reg = s.osc;
			IDX_PC_MASK: rd_reg = {2'h0, s.chg_mask};
			default: rd_reg = 8'h00;
		endcase
	endfunction

	logic req;
	logic wr;
	logic ind;
	logic tvalid;
	logic self_acc;
	logic pc_wr;
	logic [7:0] idx;
	logic [7:0] tgt;
	logic [7:0] wd;
	logic [PORT_W-1:0] mismatch;
	logic core_hit;
	logic per_hit;

	always_comb begin
		n = r;
		pc_wr = 1'b0;
		// The first stage feeds only the second; pins count once
		// the second and third stages agree.
		n.s1 = port_a_pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.pins = (r.s2 & r.s3) | (r.pins & (r.s2 ^ r.s3));
		req = wb_cyc & wb_stb;
		n.ack = req & ~r.ack;
		idx = wb_adr[ADR_W-1:2];
		ind = (idx == IDX_IND_PORT);
		// Bank bit high points beyond the implemented map.
		tgt = ind ? r.ptr : idx;
		tvalid = !(ind && r.bank);
		self_acc = ind && is_self(r.ptr);
		wd = wb_wdat[7:0];
		wr = req & r.ack & wb_we & wb_sel[0];
		// Read data and read side effects belong to the first edge.
		if (req && !r.ack) begin
			n.rdat = 8'h00;
			if (!wb_we && tvalid && !self_acc) begin
				n.rdat = rd_reg(r, tgt);
				if (tgt == IDX_PORT_A) begin
					n.last = r.pins;
				end
			end
		end
		// Writes take effect at the edge where ack is sampled.
		if (wr && tvalid && !self_acc) begin
			case (tgt)
				IDX_PC_LOW: begin
					n.pc = {r.latch[4:0], wd};
					pc_wr = 1'b1;
				end
				IDX_BANK: n.bank = wd[B_BANK];
				IDX_IND_PTR: n.ptr = wd;
				IDX_PORT_A: n.last = r.pins;
				IDX_PC_LATCH: n.latch = wd & LATCH_MASK;
				IDX_IRQ_CTL: n.irq_ctl = wd;
				IDX_PER_FLAG: n.pir = wd & PER_MASK;
				IDX_PER_EN: n.pie = wd & PER_MASK;
				IDX_RST_CAUSE: n.rst_cause = wd & RST_CAUSE_MASK;
				IDX_OSC_TRIM: n.osc = wd & OSC_MASK;
				IDX_PC_MASK: n.chg_mask = wd[PORT_W-1:0];
				default: begin
				end
			endcase
		end
		// A software write to the low byte outranks the sequencer.
		// The latch is never touched here; the pointer wraps freely.
		if (!pc_wr) begin
			if (seq_irq_branch) begin
				n.stk[r.sp] = r.pc;
				n.sp = r.sp + 1'b1;
				n.pc = IRQ_VECTOR;
				n.irq_ctl[B_GLOBAL_EN] = 1'b0;
			end else if (seq_call) begin
				n.stk[r.sp] = r.pc;
				n.sp = r.sp + 1'b1;
				n.pc = {r.latch[4:3], seq_addr};
			end else if (seq_goto) begin
				n.pc = {r.latch[4:3], seq_addr};
			end else if (seq_ret || seq_return_from_irq) begin
				n.sp = r.sp - 1'b1;
				n.pc = r.stk[SP_W'(r.sp - 1'b1)];
				if (seq_return_from_irq) begin
					n.irq_ctl[B_GLOBAL_EN] = 1'b1;
				end
			end else if (seq_step) begin
				n.pc = r.pc + 1'b1;
			end
		end
		// Hardware events are applied last, so an event beats a software write to the same bit.
		mismatch = (r.pins ^ r.last) & r.chg_mask;
		if (ev_timer_zero_ovf) begin
			n.irq_ctl[B_T0_FLAG] = 1'b1;
		end
		if (ev_ext_pin) begin
			n.irq_ctl[B_EXT_FLAG] = 1'b1;
		end
		if (|mismatch) begin
			n.irq_ctl[B_CHG_FLAG] = 1'b1;
		end
		if (ev_mem_write_done) begin
			n.pir[B_MEMW] = 1'b1;
		end
		if (ev_conversion_done) begin
			n.pir[B_CONV] = 1'b1;
		end
		if (ev_comparator_change) begin
			n.pir[B_CMP] = 1'b1;
		end
		if (ev_timer_one_ovf) begin
			n.pir[B_T1] = 1'b1;
		end
		if (ev_brownout) begin
			n.rst_cause[B_BROWNOUT] = 1'b0;
		end
		core_hit = |(r.irq_ctl[5:3] & r.irq_ctl[2:0]);
		per_hit = r.irq_ctl[B_PER_GATE] & (|(r.pie & r.pir));
		n.irq = r.irq_ctl[B_GLOBAL_EN] & (core_hit | per_hit);
	end

	// Reset also clears the program counter and stack pointer.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
			r.osc <= OSC_RST;
		end else begin
			r <= n;
		end
	end

	assign wb_rdat = {24'h000000, r.rdat};
	assign wb_ack = r.ack;
	assign pc = r.pc;
	assign irq_req = r.irq;
	assign osc_trim_code = r.osc[7:2];

	chk_ack_after_req: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
		else $error("Bus answer not a single cycle pulse.");

	chk_flag_no_enable: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		ev_timer_zero_ovf |=> r.irq_ctl[B_T0_FLAG])
		else $error("Timer zero flag did not set.");

	chk_irq_global_gate: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		irq_req |-> $past(r.irq_ctl[B_GLOBAL_EN]))
		else $error("Request raised with global enable clear.");

	chk_periph_gate: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!r.irq_ctl[B_PER_GATE] && !core_hit) |=> !irq_req)
		else $error("Peripheral request passed a closed gate.");

	chk_irq_raise: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(r.irq_ctl[B_GLOBAL_EN] && r.irq_ctl[B_T0_EN] &&
		r.irq_ctl[B_T0_FLAG]) |=> irq_req)
		else $error("Enabled pending flag gave no request.");

	chk_low_byte_load: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(wr && !ind && idx == IDX_PC_LOW) |=>
		pc == {$past(r.latch[4:0]), $past(wb_wdat[7:0])})
		else $error("Low byte write loaded a wrong counter.");

	chk_call_upper: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_call && !seq_irq_branch && !wr) |=>
		pc == {$past(r.latch[4:3]), $past(seq_addr)})
		else $error("Call target not formed from latch bits.");

	chk_pop_restores: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_call && !seq_irq_branch && !wr) ##1
		(seq_ret && !seq_call && !seq_irq_branch && !wr)
		|=> pc == $past(pc, 2))
		else $error("Return did not restore the pushed counter.");

	chk_brownout_clear: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		ev_brownout |=> !r.rst_cause[B_BROWNOUT] &&
		r.rst_cause[7:2] == 6'h00)
		else $error("Brown-out bit not cleared by event.");

	chk_pin_change: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(|((r.pins ^ r.last) & r.chg_mask)) |=> r.irq_ctl[B_CHG_FLAG])
		else $error("Pin mismatch did not set change flag.");

	chk_self_indirect: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(req && !r.ack && ind && r.ptr == IDX_IND_PORT)
		|=> wb_rdat == 32'h00000000)
		else $error("Indirect self read returned data.");

	chk_trim_low_zero: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		r.osc[1:0] == 2'h0 ##1 r.osc[1:0] == 2'h0)
		else $error("Trim low bits not zero.");

	chk_t0_flag_sticky: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(r.irq_ctl[B_T0_FLAG] && !wr) |=> r.irq_ctl[B_T0_FLAG])
		else $error("Timer zero flag cleared without software.");

	chk_per_flag_sticky: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(r.pir[B_MEMW] && !wr) |=> r.pir[B_MEMW])
		else $error("Write done flag cleared without software.");

	chk_per_enable_mask: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(wr && !ind && idx == IDX_PER_EN) |=>
		r.pie == ($past(wb_wdat[7:0]) & PER_MASK))
		else $error("Peripheral enable write not masked.");

	// No disable here: the counter must read zero while reset holds.
	chk_reset_clears_pc: assert property (
		@(posedge sys_clk)
		!rstn |-> pc == '0)
		else $error("Program counter not cleared in reset.");

	chk_step_advance: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_step && !seq_call && !seq_goto && !seq_ret &&
		!seq_return_from_irq && !seq_irq_branch && !wr) |=>
		pc == PC_W'($past(pc) + 1'b1))
		else $error("Step did not advance the counter.");

	chk_goto_upper: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_goto && !seq_call && !seq_irq_branch && !wr) |=>
		pc == {$past(r.latch[4:3]), $past(seq_addr)})
		else $error("Jump target not formed from latch bits.");

	chk_stack_wraps: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_call && !seq_irq_branch && !wr) |=>
		r.sp == SP_W'($past(r.sp) + 1'b1))
		else $error("Stack pointer did not advance circularly.");

	chk_pop_silent: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_ret && !seq_call && !seq_goto && !seq_irq_branch && !wr) |=>
		r.sp == SP_W'($past(r.sp) - 1'b1))
		else $error("Stack pointer did not step back on a pop.");

	chk_latch_untouched: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		((seq_call || seq_ret || seq_irq_branch) && !wr) |=>
		r.latch == $past(r.latch))
		else $error("Upper latch changed by a push or pop.");

	chk_irq_vectors: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(seq_irq_branch && !wr) |=>
		pc == IRQ_VECTOR && !r.irq_ctl[B_GLOBAL_EN])
		else $error("Interrupt branch did not reach the vector.");

	chk_bank_blocks: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(req && !r.ack && ind && r.bank) |=> wb_rdat == 32'h00000000)
		else $error("Indirect access above the map returned data.");

	chk_per_irq_raise: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(r.irq_ctl[B_GLOBAL_EN] && r.irq_ctl[B_PER_GATE] &&
		r.pie[B_T1] && r.pir[B_T1]) |=> irq_req)
		else $error("Enabled peripheral flag gave no request.");

endmodule
`default_nettype wire

// File: core_pkg.sv
// Purpose: Shared constants of the core interrupt and program-flow block.
// Assumes: Register index times four is the Wishbone byte address.
// Notes: Only the low byte lane of each word carries register data.
package core_pkg;
	localparam int ADR_W = 10;
	localparam int PC_W = 13;
	localparam int JMP_W = 11;
	localparam int PORT_W = 6;
	// Register indices.
	localparam logic [7:0] IDX_IND_PORT = 8'h00;
	localparam logic [7:0] IDX_IND_PORT_B1 = 8'h80;
	localparam logic [7:0] IDX_PC_LOW = 8'h02;
	localparam logic [7:0] IDX_BANK = 8'h03;
	localparam logic [7:0] IDX_IND_PTR = 8'h04;
	localparam logic [7:0] IDX_PORT_A = 8'h05;
	localparam logic [7:0] IDX_PC_LATCH = 8'h0A;
	localparam logic [7:0] IDX_IRQ_CTL = 8'h0B;
	localparam logic [7:0] IDX_PER_FLAG = 8'h0C;
	localparam logic [7:0] IDX_PER_EN = 8'h8C;
	localparam logic [7:0] IDX_RST_CAUSE = 8'h8E;
	localparam logic [7:0] IDX_OSC_TRIM = 8'h90;
	localparam logic [7:0] IDX_PC_MASK = 8'h96;
	// Interrupt control bit positions.
	localparam int B_GLOBAL_EN = 7;
	localparam int B_PER_GATE = 6;
	localparam int B_T0_EN = 5;
	localparam int B_EXT_EN = 4;
	localparam int B_CHG_EN = 3;
	localparam int B_T0_FLAG = 2;
	localparam int B_EXT_FLAG = 1;
	localparam int B_CHG_FLAG = 0;
	// Peripheral flag and enable bit positions.
	localparam int B_MEMW = 7;
	localparam int B_CONV = 6;
	localparam int B_CMP = 3;
	localparam int B_T1 = 0;
	localparam logic [7:0] PER_MASK = 8'hC9;
	// Reset cause bits.
	localparam int B_POWERON = 1;
	localparam int B_BROWNOUT = 0;
	localparam logic [7:0] RST_CAUSE_MASK = 8'h03;
	// Oscillator trim, upper latch and bank bit position.
	localparam logic [7:0] OSC_MASK = 8'hFC;
	localparam logic [7:0] OSC_RST = 8'h80;
	localparam logic [7:0] LATCH_MASK = 8'h1F;
	localparam int B_BANK = 7;
	// Reset values and interrupt vector.
	localparam logic [7:0] IRQ_CTL_RST = 8'h00;
	localparam logic [7:0] PER_FLAG_RST = 8'h00;
	localparam logic [7:0] PER_EN_RST = 8'h00;
	localparam logic [7:0] RST_CAUSE_RST = 8'h00;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
endpackage

// File: core_seq_model.sv
// Purpose: Stand-in for the instruction sequencer and event sources.
// Assumes: Every strobe is a one-cycle pulse launched after a rising edge.
// Notes: Between pulses the jump field shows junk, as a real one may.
`timescale 1ns/1ns
`default_nettype none
module core_seq_model (
	// Clock.
	input wire logic sys_clk,
	// Sequencer strobes and event pulses, step first, brown-out last.
	output logic [12:0] strobes,
	output logic [10:0] jump_addr
);
	initial begin
		strobes = 13'h0000;
		jump_addr = 11'h000;
	end
	// The far side only pulses; flag clearing order is up to software.
	task automatic pulse(input logic [12:0] m, input logic [10:0] a);
		@(posedge sys_clk);
		strobes <= m;
		jump_addr <= a;
		@(posedge sys_clk);
		strobes <= 13'h0000;
		jump_addr <= ~a;
	endtask
	// Two strobes on successive cycles, as a call straight into a return.
	task automatic pair(input logic [12:0] m1, input logic [12:0] m2,
		input logic [10:0] a);
		@(posedge sys_clk);
		strobes <= m1;
		jump_addr <= a;
		@(posedge sys_clk);
		strobes <= m2;
		@(posedge sys_clk);
		strobes <= 13'h0000;
		jump_addr <= ~a;
	endtask
endmodule
`default_nettype wire

// File: core_irq_and_program_flow_tb_top.sv
// Purpose: Self-checking bench for the core interrupt and flow block.
// Assumes: One 25 MHz clock, Wishbone classic slave answering once.
// Notes: Read results are queued by the driver and checked on ack.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
	mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module core_irq_and_program_flow_tb_top;
	import core_pkg::*;
	localparam logic [12:0] STEP = 13'h1000;
	localparam logic [12:0] CALL = 13'h0800;
	localparam logic [12:0] GOTO = 13'h0400;
	localparam logic [12:0] RET = 13'h0200;
	localparam logic [12:0] RET_IRQ = 13'h0100;
	localparam logic [12:0] IRQB = 13'h0080;
	localparam logic [12:0] T0 = 13'h0040;
	localparam logic [12:0] ALLEV = 13'h007E;
	localparam logic [12:0] T1 = 13'h0002;
	localparam logic [12:0] BROWN = 13'h0001;
	logic sys_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, irq_req;
	logic [ADR_W-1:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat, rs, got_exp, exp_q[$];
	logic [12:0] st;
	logic [10:0] ja;
	logic [PC_W-1:0] pc;
	logic [PORT_W-1:0] pins;
	logic [5:0] trim;
	logic [7:0] d;
	int mismatches, cmp_count;
	core_irq_flow i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack),
		.seq_step(st[12]), .seq_call(st[11]), .seq_goto(st[10]),
		.seq_ret(st[9]), .seq_return_from_irq(st[8]),
		.seq_irq_branch(st[7]),
		.seq_addr(ja), .pc(pc), .irq_req(irq_req),
		.ev_timer_zero_ovf(st[6]), .ev_ext_pin(st[5]),
		.ev_mem_write_done(st[4]), .ev_conversion_done(st[3]),
		.ev_comparator_change(st[2]), .ev_timer_one_ovf(st[1]),
		.ev_brownout(st[0]), .port_a_pins(pins), .osc_trim_code(trim));
	core_seq_model i_seq (.sys_clk(sys_clk), .strobes(st), .jump_addr(ja));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic summarize();
		$display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// The master waits for ack however long it takes, up to a limit.
	task automatic req(input logic [7:0] i, input logic w, input logic [7:0] v);
		int n;
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_sel <= 4'hF;
		wb_adr <= {i, 2'b00};
		wb_wdat <= {24'h0, v};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (wb_ack !== 1'b1) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		req(i, 1'b1, v);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		req(i, 1'b0, 8'h00);
	endtask
	task automatic cpc(input logic [12:0] e);
		@(negedge sys_clk);
		`CHK(pc, e)
	endtask
	task automatic cirq(input logic e);
		// Look at the request mid-cycle, clear of the edge that sets it.
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(irq_req, e)
	endtask
	always @(posedge sys_clk)
		if (wb_ack === 1'b1 && wb_we === 1'b0) begin
			got_exp = exp_q.pop_front();
			`CHK(wb_rdat, got_exp)
		end
	initial begin
		rs = 32'd49;
		{rstn, wb_cyc, wb_stb, wb_we} = 4'h0;
		{wb_adr, wb_wdat, pins} = '0;
		wb_sel = 4'hF;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		cpc(13'h0000);
		rd(IDX_IRQ_CTL, 8'h00);
		rd(IDX_PER_EN, 8'h00);
		rd(IDX_RST_CAUSE, 8'h00);
		rd(IDX_OSC_TRIM, 8'h80);
		wr(IDX_OSC_TRIM, 8'hFF);
		rd(IDX_OSC_TRIM, 8'hFC);
		`CHK(trim, 6'h3F)
		rd(8'hFF, 8'h00);
		i_seq.pulse(ALLEV, 11'h000);
		rd(IDX_IRQ_CTL, 8'h06);
		rd(IDX_PER_FLAG, 8'hC9);
		cirq(1'b0);
		wr(IDX_PER_FLAG, 8'h00);
		wr(IDX_IRQ_CTL, 8'hA0);
		cirq(1'b0);
		i_seq.pulse(T0, 11'h000);
		cirq(1'b1);
		wr(IDX_IRQ_CTL, 8'h80);
		wr(IDX_PER_EN, 8'h01);
		i_seq.pulse(T1, 11'h000);
		cirq(1'b0);
		wr(IDX_IRQ_CTL, 8'hC0);
		cirq(1'b1);
		wr(IDX_IRQ_CTL, 8'h40);
		cirq(1'b0);
		wr(IDX_IND_PTR, IDX_PER_EN);
		wr(IDX_IND_PORT, 8'hFF);
		rd(IDX_PER_EN, 8'hC9);
		wr(IDX_IND_PTR, IDX_IND_PORT);
		rd(IDX_IND_PORT, 8'h00);
		wr(IDX_BANK, 8'h80);
		wr(IDX_IND_PTR, IDX_PER_EN);
		rd(IDX_IND_PORT, 8'h00);
		wr(IDX_BANK, 8'h00);
		wr(IDX_RST_CAUSE, 8'hFF);
		rd(IDX_RST_CAUSE, 8'h03);
		i_seq.pulse(BROWN, 11'h000);
		rd(IDX_RST_CAUSE, 8'h02);
		wr(IDX_IRQ_CTL, 8'h08);
		wr(IDX_PC_MASK, 8'h3F);
		wr(IDX_PORT_A, 8'h00);
		pins <= 6'(xs() | 32'h1);
		repeat (6) @(posedge sys_clk);
		rd(IDX_IRQ_CTL, 8'h09);
		// Reading the port ends the mismatch, so the flag can be cleared.
		rd(IDX_PORT_A, {2'h0, pins});
		d = 8'(xs());
		wr(IDX_PC_LATCH, 8'hFF);
		wr(IDX_PC_LOW, d);
		cpc({5'h1F, d});
		i_seq.pulse(STEP, 11'h000);
		cpc({5'h1F, d} + 13'h1);
		i_seq.pulse(GOTO, 11'h000);
		cpc(13'h1800);
		for (int i = 1; i <= 9; i++)
			i_seq.pulse(CALL, 11'(i));
		cpc(13'h1809);
		for (int j = 1; j <= 9; j++) begin
			i_seq.pulse(RET, 11'h000);
			cpc(13'h1800 | 13'(j < 9 ? 9 - j : 8));
		end
		rd(IDX_PC_LATCH, 8'h1F);
		wr(IDX_IRQ_CTL, 8'h80);
		i_seq.pulse(IRQB, 11'h000);
		cpc(IRQ_VECTOR);
		rd(IDX_IRQ_CTL, 8'h00);
		i_seq.pulse(RET_IRQ, 11'h000);
		cpc(13'h1808);
		rd(IDX_IRQ_CTL, 8'h80);
		i_seq.pair(CALL, RET, 11'h055);
		cpc(13'h1808);
		rstn <= 1'b0;
		cpc(13'h0000);
		`CHK(trim, 6'h20)
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(IDX_OSC_TRIM, 8'h80);
		rd(IDX_RST_CAUSE, 8'h00);
		repeat (3) @(posedge sys_clk);
		summarize();
	end
endmodule
`default_nettype wire
